// ===== logic/sca_device.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Checksum is CRC8 with generator 0x107
// [R2] Checksum register preset to FFh
// [R3] Words fed bit 15 first, shift-insert-XOR
// [R4] Checksum covers addresses 0h to Eh ascending
// [R5] Stored checksum byte zeroed before computing
// [R6] Command mode only via 94h write B96Ah
// [R7] Bit 15 shows true diagnostic condition
// [R8] Bit 14 forces diagnostic off, resets 0
// [R9] Bit 12 set on low supply voltage
// [R10] Bit 8 sticky corrected error per readout
// [R11] Bit 7 sticky double error per readout
// [R12] Bit 6 sticky field loss, gated diagnostic
// [R13] Bit 5 sticky broken bond wire
// [R14] Bit 4 checksum mismatch at start-up
// [R15] Bits 3 and 2 show angle range
// [R16] Reads everywhere, writes customer words only
// [R17] Writes to reserved areas silently dropped
// [R18] Master waits programming time after writes; the master waits only after NVM-region writes, not register writes
// [R19] Command byte: region, address, read bit
// [R20] Command mode held until power-on reset
// [R21] Reserved status bits read zero
module sca_device #(
   parameter int CMD_ENT_CYCLES = sca_pkg::CMD_ENT_CYC,  // Entry window
   parameter int ANGLE_W        = 12                     // Angle width
) (
   input  wire logic               clk,            // Device clock
   input  wire logic               srst,           // Power-on reset
   input  wire logic               nvm_init,       // Load defaults at reset
   sca_link_if.device              lnk,            // Programming link
   input  wire logic               undervoltage,   // Low supply detected
   input  wire logic               mem_readout,    // Memory readout strobe
   input  wire logic               single_err,     // Corrected error seen
   input  wire logic               double_err,     // Uncorrectable error
   input  wire logic               field_loss,     // Magnet lost
   input  wire logic               field_loss_en,  // Field loss detect on
   input  wire logic               wire_break,     // Bond wire broken
   input  wire logic [ANGLE_W-1:0] angle,          // Measured angle
   input  wire logic [ANGLE_W-1:0] upper_angle_limit, // High threshold
   input  wire logic [ANGLE_W-1:0] lower_angle_limit, // Low threshold
   input  wire logic [3:0]         cfg_addr,       // Config word select
   output logic      [15:0]        cfg_data,       // Config word
   output logic                    command_mode,   // In command mode
   output logic                    diag_out,       // Diagnostic output
   output logic                    crc_busy        // Start-up check running
);

   localparam int WIN_W = $clog2(CMD_ENT_CYCLES + 1);

   typedef struct packed {
      logic [15:0][15:0] nvm;        // Configuration words
      logic              cmd_mode;   // Command mode entered
      logic              win_open;   // Entry window still open
      logic [WIN_W-1:0]  win_cnt;    // Cycles since reset
      logic              override;   // diagnostic_override
      logic              uv;         // undervoltage_flag
      logic              sfix;       // Corrected error flag
      logic              dbl;        // double_bit_fault_flag
      logic              fl;         // field_loss_flag
      logic              wb;         // wire_break_flag
      logic              crc_bad;    // Checksum mismatch
      logic              crc_run;    // Start-up check running
      logic [3:0]        crc_idx;    // Word being folded
      logic [7:0]        crc;        // Running checksum
      logic [15:0]       rdata;      // Read answer
      logic              rvalid;     // Read answer strobe
   } sca_dev_s;

   sca_dev_s q;
   sca_dev_s d;

   logic        above;
   logic        below;
   logic        cond;
   logic [15:0] diag_word;
   logic [2:0]  region;
   logic [3:0]  addr;
   logic        is_rd;
   logic [15:0] crc_in;
   logic [7:0]  crc_nx;

   // ***********************************************************
   // Live conditions and status word
   // ***********************************************************
   assign above  = angle > upper_angle_limit;              // [R15]
   assign below  = angle < lower_angle_limit;              // [R15]
   // Field loss only raises the condition while detection is on
   assign cond   = q.uv | q.sfix | q.dbl | (q.fl & field_loss_en) |
                   q.wb | q.crc_bad | above | below;       // [R12]

   // Status word, reserved positions held at zero
   always_comb begin
      diag_word = 16'h0000;                                // [R21]
      diag_word[sca_pkg::DIAG_ACTIVE_BIT]   = cond;        // [R7]
      diag_word[sca_pkg::DIAG_OVERRIDE_BIT] = q.override;  // [R8]
      diag_word[sca_pkg::UNDERVOLT_BIT]     = q.uv;        // [R9]
      diag_word[sca_pkg::SINGLE_FIX_BIT]    = q.sfix;      // [R10]
      diag_word[sca_pkg::DOUBLE_BIT]        = q.dbl;       // [R11]
      diag_word[sca_pkg::FIELD_LOSS_BIT]    = q.fl;        // [R12]
      diag_word[sca_pkg::WIRE_BREAK_BIT]    = q.wb;        // [R13]
      diag_word[sca_pkg::CRC_BAD_BIT]       = q.crc_bad;   // [R14]
      diag_word[sca_pkg::ABOVE_BIT]         = above;       // [R15]
      diag_word[sca_pkg::BELOW_BIT]         = below;       // [R15]
   end

   // ***********************************************************
   // Command decode
   // ***********************************************************
   assign region = lnk.cmd[sca_pkg::CMD_REGION_HI:sca_pkg::CMD_REGION_LO];
   assign addr   = lnk.cmd[sca_pkg::CMD_ADDR_HI:sca_pkg::CMD_ADDR_LO];
   assign is_rd  = lnk.cmd[sca_pkg::CMD_RD_BIT];           // [R19]

   // Word fed to the checksum, stored byte of the last word zeroed
   always_comb begin
      crc_in = q.nvm[q.crc_idx];
      if (q.crc_idx == sca_pkg::CRC_LAST) begin
         crc_in[7:0] = 8'h00;                              // [R5]
      end
   end

   assign crc_nx = sca_pkg::crc_word(q.crc, crc_in);       // [R1] [R3]

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      d        = q;
      d.rvalid = 1'b0;

      // Entry window counts once from reset, then closes for good
      if (q.win_open) begin
         if (q.win_cnt == WIN_W'(CMD_ENT_CYCLES - 1)) begin
            d.win_open = 1'b0;
         end else begin
            d.win_cnt = q.win_cnt + WIN_W'(1);
         end
      end

      // Link transactions
      if (lnk.req) begin
         if (!q.cmd_mode) begin
            // Only the unlock write is heard before command mode
            if (lnk.cmd == sca_pkg::CMD_SIGN_WR && q.win_open &&
                lnk.wdata == sca_pkg::UNLOCK_VALUE) begin
               d.cmd_mode = 1'b1;                          // [R6]
            end
         end else if (is_rd) begin
            // Every area may be read; unmapped reads answer zero
            d.rvalid = 1'b1;                               // [R16]
            if (region == sca_pkg::REGION_NVM) begin
               d.rdata = q.nvm[addr];
            end else if (region == sca_pkg::REGION_REG &&
                         addr == sca_pkg::ADDR_DIAG) begin
               d.rdata = diag_word;
            end else begin
               d.rdata = 16'h0000;
            end
         end else begin
            // Writes land in customer words and the override only
            if (region == sca_pkg::REGION_NVM &&
                sca_pkg::CUST_WR_MASK[addr]) begin
               d.nvm[addr] = lnk.wdata;                    // [R16]
            end else if (region == sca_pkg::REGION_REG &&
                         addr == sca_pkg::ADDR_DIAG) begin
               d.override = lnk.wdata[sca_pkg::DIAG_OVERRIDE_BIT]; // [R8]
            end
            // Any other write target is dropped here      // [R17]
         end
      end

      // Sticky fault flags, cleared only by reset
      d.uv   = q.uv | undervoltage;                        // [R9]
      d.sfix = q.sfix | (mem_readout & single_err);        // [R10]
      d.dbl  = q.dbl | (mem_readout & double_err);         // [R11]
      d.fl   = q.fl | field_loss;                          // [R12]
      d.wb   = q.wb | wire_break;                          // [R13]

      // Start-up checksum, one word per cycle in rising order
      if (q.crc_run) begin
         d.crc = crc_nx;
         if (q.crc_idx == sca_pkg::CRC_LAST) begin         // [R4]
            d.crc_run = 1'b0;
            d.crc_bad = crc_nx != q.nvm[sca_pkg::CRC_LAST][7:0]; // [R14]
         end else begin
            d.crc_idx = q.crc_idx + 4'h1;                  // [R4]
         end
      end

      // Power-on reset; configuration words survive it unless nvm_init loads the defaults
      if (srst) begin
         d          = '0;
         d.nvm      = nvm_init ? sca_pkg::NVM_DEFAULT : q.nvm;
         d.win_open = 1'b1;
         d.override = sca_pkg::OVERRIDE_RESET;             // [R8]
         d.crc_run  = 1'b1;
         d.crc      = sca_pkg::CRC_INIT;                   // [R2]
         d.cmd_mode = 1'b0;                                // [R20]
      end
   end

   // State register
   always_ff @(posedge clk) begin
      q <= d;
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign lnk.rdata    = q.rdata;
   assign lnk.rvalid   = q.rvalid;
   assign cfg_data     = q.nvm[cfg_addr];
   assign command_mode = q.cmd_mode;                       // [R20]
   assign diag_out     = cond & ~q.override;               // [R8]
   assign crc_busy     = q.crc_run;

endmodule

// ===== logic/sca_link_if.sv
`timescale 1ns/1ps
interface sca_link_if;
   logic        req;     // Master: one-cycle transaction strobe
   logic [7:0]  cmd;     // Master: command byte
   logic [15:0] wdata;   // Master: write data
   logic [15:0] rdata;   // Device: read data
   logic        rvalid;  // Device: one-cycle read answer strobe

   modport device (input req, input cmd, input wdata,
                   output rdata, output rvalid);
   modport master (output req, output cmd, output wdata,
                   input rdata, input rvalid);
endinterface

// ===== logic/sca_master.sv
`timescale 1ns/1ps
module sca_master #(
   parameter int TPROG_CYCLES = sca_pkg::TPROG_CYC,  // Programming wait
   parameter int RD_TIMEOUT   = sca_pkg::RD_TIMEOUT  // Read answer wait
) (
   input  wire logic        clk,          // Clock
   input  wire logic        srst,         // Reset
   sca_link_if.master       lnk,          // Programming link
   input  wire logic        usr_req,      // Transaction request
   input  wire logic [7:0]  usr_cmd,      // Command byte
   input  wire logic [15:0] usr_wdata,    // Write data
   output logic             usr_ready,    // Can take a request
   output logic [15:0]      usr_rdata,    // Read data
   output logic             usr_rvalid,   // Read data strobe
   output logic             usr_rtimeout, // Read went unanswered
   input  wire logic        crc_clear,    // Preset checksum
   input  wire logic        crc_valid,    // Fold a word
   input  wire logic [3:0]  crc_index,    // Address of that word
   input  wire logic [15:0] crc_data,     // Word value
   output logic [7:0]       crc_value     // Running checksum
);

   localparam int CNT_W = $clog2(TPROG_CYCLES + RD_TIMEOUT + 1);

   typedef enum {M_IDLE, M_WAIT_RD, M_PROG} sca_mst_e;

   typedef struct packed {
      sca_mst_e          st;      // Transaction state
      logic [CNT_W-1:0]  cnt;     // Wait counter
      logic              req;     // Link strobe
      logic [7:0]        cmd;     // Command byte
      logic [15:0]       wdata;   // Write data
      logic [15:0]       rdata;   // Read data
      logic              rvalid;  // Read strobe
      logic              rto;     // Timeout strobe
      logic [7:0]        crc;     // Checksum
   } sca_mst_s;

   sca_mst_s    q;
   sca_mst_s    d;
   logic [15:0] crc_in;

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      d        = q;
      d.req    = 1'b0;
      d.rvalid = 1'b0;
      d.rto    = 1'b0;
      crc_in   = crc_data;
      case (q.st)
         M_IDLE: begin
            if (usr_req && !q.req) begin
               d.req   = 1'b1;
               d.cmd   = usr_cmd;
               d.wdata = usr_wdata;
               d.cnt   = '0;
               if (usr_cmd[sca_pkg::CMD_RD_BIT]) begin
                  d.st = M_WAIT_RD;
               end else if (usr_cmd[sca_pkg::CMD_REGION_HI:
                                    sca_pkg::CMD_REGION_LO] ==
                            sca_pkg::REGION_NVM) begin
                  d.st = M_PROG;                     // [R18]
               end
            end
         end
         M_WAIT_RD: begin
            if (lnk.rvalid) begin
               d.rdata  = lnk.rdata;
               d.rvalid = 1'b1;
               d.st     = M_IDLE;
            end else if (q.cnt == CNT_W'(RD_TIMEOUT - 1)) begin
               d.rto = 1'b1;
               d.st  = M_IDLE;
            end else begin
               d.cnt = q.cnt + CNT_W'(1);
            end
         end
         M_PROG: begin
            // No access at all until programming has had its time
            if (q.cnt == CNT_W'(TPROG_CYCLES - 1)) begin
               d.st = M_IDLE;                        // [R18]
            end else begin
               d.cnt = q.cnt + CNT_W'(1);
            end
         end
         default: d.st = M_IDLE;
      endcase

      // Checksum helper for recomputing the stored byte
      if (crc_valid && crc_index == sca_pkg::CRC_LAST) begin
         crc_in[7:0] = 8'h00;                        // [R5]
      end
      if (crc_clear) begin
         d.crc = sca_pkg::CRC_INIT;                  // [R2]
      end else if (crc_valid) begin
         d.crc = sca_pkg::crc_word(q.crc, crc_in);   // [R1] [R3] [R4]
      end

      if (srst) begin
         d     = '0;
         d.st  = M_IDLE;
         d.crc = sca_pkg::CRC_INIT;                  // [R2]
      end
   end

   // State register
   always_ff @(posedge clk) begin
      q <= d;
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign lnk.req      = q.req;
   assign lnk.cmd      = q.cmd;
   assign lnk.wdata    = q.wdata;
   assign usr_ready    = (q.st == M_IDLE) && !q.req;  // [R18]
   assign usr_rdata    = q.rdata;
   assign usr_rvalid   = q.rvalid;
   assign usr_rtimeout = q.rto;
   assign crc_value    = q.crc;

endmodule

// ===== logic/sca_pkg.sv
package sca_pkg;

   // ***********************************************************
   // Clock and timing
   // ***********************************************************
   localparam int CLK_PS        = 5000;         // 200 MHz clock period
   localparam int TPROG_US      = 20;           // Programming time per write
   localparam int TPROG_CYC     = (TPROG_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam int CMD_ENT_US    = 30000;        // Command entry window
   localparam int CMD_ENT_CYC   = (CMD_ENT_US / 1000) * (1000000000 / CLK_PS);
   localparam int RD_TIMEOUT    = 16;           // Master wait for a read answer

   // ***********************************************************
   // Command byte layout
   // ***********************************************************
   localparam int CMD_REGION_HI = 7;            // Region field top bit
   localparam int CMD_REGION_LO = 5;            // Region field low bit
   localparam int CMD_ADDR_HI   = 4;            // Word address top bit
   localparam int CMD_ADDR_LO   = 1;            // Word address low bit
   localparam int CMD_RD_BIT    = 0;            // Read (1) or write (0)
   localparam logic [2:0] REGION_NVM = 3'h0;    // Non-volatile words
   localparam logic [2:0] REGION_REG = 3'h4;    // Registers

   // ***********************************************************
   // Register map inside the register region
   // ***********************************************************
   localparam logic [3:0] ADDR_DIAG  = 4'h1;    // diag_control_status
   localparam logic [3:0] ADDR_SIGN  = 4'hA;    // unlock_signature
   localparam logic [7:0] CMD_SIGN_WR = 8'h94;  // Write command for unlock
   localparam logic [15:0] UNLOCK_VALUE = 16'hB96A;

   // ***********************************************************
   // diag_control_status fields
   // ***********************************************************
   localparam int DIAG_ACTIVE_BIT   = 15;       // diagnostic_active_flag
   localparam int DIAG_OVERRIDE_BIT = 14;       // diagnostic_override
   localparam int UNDERVOLT_BIT     = 12;       // undervoltage_flag
   localparam int SINGLE_FIX_BIT    = 8;        // Corrected single-bit error
   localparam int DOUBLE_BIT        = 7;        // double_bit_fault_flag
   localparam int FIELD_LOSS_BIT    = 6;        // field_loss_flag
   localparam int WIRE_BREAK_BIT    = 5;        // wire_break_flag
   localparam int CRC_BAD_BIT       = 4;        // Checksum mismatch
   localparam int ABOVE_BIT         = 3;        // angle_above_range_flag
   localparam int BELOW_BIT         = 2;        // angle_below_range_flag
   localparam logic OVERRIDE_RESET  = 1'b0;     // diagnostic_override reset

   // ***********************************************************
   // Checksum
   // ***********************************************************
   localparam logic [8:0] CRC_GEN  = 9'h107;    // x^8 + x^2 + x + 1
   localparam logic [7:0] CRC_INIT = 8'hFF;     // Preset value
   localparam logic [3:0] CRC_LAST = 4'hE;      // Last covered address
   localparam logic [15:0] CUST_WR_MASK = 16'h7FFF; // Writable NVM words
   localparam logic [255:0] NVM_DEFAULT = {
      16'h0000, 16'h00DB, 16'h0FFF, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0FFF, 16'h0000,
      16'h0FFF, 16'h0800, 16'h0000, 16'h0818};

   // Fold one word into the checksum, bit 15 first
   function automatic logic [7:0] crc_word(input logic [7:0]  c,
                                           input logic [15:0] w);
      logic [8:0] t;
      logic [7:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         t = {r, w[i]};
         if (t[8]) begin
            t = t ^ CRC_GEN;
         end
         r = t[7:0];
      end
      return r;
   endfunction

endpackage

// ===== sim/sca_link_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Link checker
// ****************************************
module sca_link_monitor #(
   parameter int CMD_ENT_CYCLES = sca_pkg::CMD_ENT_CYC  // Entry window
) (
   input wire logic        clk,           // Clock
   input wire logic        srst,          // Reset
   input wire logic        req,           // Request strobe
   input wire logic [7:0]  cmd,           // Command byte
   input wire logic [15:0] wdata,         // Write data
   input wire logic [15:0] rdata,         // Read data
   input wire logic        rvalid         // Read answer strobe
);
   int   win_q;
   logic unl_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Age of the entry window and unlock seen on the wire
   always_ff @(posedge clk) begin
      if (srst) begin
         win_q <= 0;
         unl_q <= 1'b0;
      end else begin
         win_q <= (win_q < CMD_ENT_CYCLES) ? win_q + 1 : win_q;
         if (req && cmd == sca_pkg::CMD_SIGN_WR && win_q < CMD_ENT_CYCLES
             && wdata == sca_pkg::UNLOCK_VALUE) begin
            unl_q <= 1'b1;
         end
      end
   end
   sequence s_read;
      req && cmd[0];
   endsequence
   sequence s_nvm_wr;
      req && cmd[7:5] == sca_pkg::REGION_NVM && !cmd[0];
   endsequence
   ans_open_a: assert property (
      s_read ##0 unl_q |=> rvalid)
      else $error("read in command mode unanswered");
   ans_locked_a: assert property (
      s_read ##0 !unl_q |=> !rvalid)
      else $error("read answered while locked");
   ans_cause_a: assert property (
      rvalid |-> $past(req) && $past(cmd[0]))
      else $error("answer without a read request");
   ans_pulse_a: assert property (
      rvalid |=> !rvalid)
      else $error("answer strobe too long");
   prog_wait_a: assert property (
      s_nvm_wr |=> !req [*8])
      else $error("access during programming time");
   diag_rsvd_a: assert property (
      rvalid && $past(cmd) == 8'h83 |-> (rdata & 16'h2E03) == 16'h0000)
      else $error("reserved status bits not zero");
   rsvd_reg_a: assert property (
      rvalid && $past(cmd[7:5]) == sca_pkg::REGION_REG
      && $past(cmd[4:1]) != sca_pkg::ADDR_DIAG |-> rdata == 16'h0000)
      else $error("reserved register not zero");
   rdata_hold_a: assert property (
      !rvalid && !$past(srst) |-> $stable(rdata))
      else $error("read data changed without answer");
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module tb;
   logic        clk, srst, nvm_init, fle, ureq, urdy, urv, uto;
   logic        cclr, cval, cm, dout, busy, to;
   logic [4:0]  ev;
   logic [11:0] ang;
   logic [7:0]  ucmd, crc;
   logic [15:0] uwd, urd, cdat, cfg, rd;
   logic [3:0]  cidx, caddr;
   int          n_errors = 0;
   int          check_count = 0;
   int          cyc = 0;
   sca_link_if lnk ();
   // Both ends and the wire checker
   sca_device #(.CMD_ENT_CYCLES(64)) u_sca_device (
      .clk, .srst, .nvm_init, .lnk(lnk), .undervoltage(ev[0]),
      .wire_break(ev[1]), .single_err(ev[2]), .double_err(ev[3]),
      .mem_readout(ev[2] | ev[3]), .field_loss(ev[4]), .field_loss_en(fle),
      .angle(ang), .upper_angle_limit(12'hC00), .lower_angle_limit(12'h400),
      .cfg_addr(caddr), .cfg_data(cfg), .command_mode(cm), .diag_out(dout),
      .crc_busy(busy));
   sca_master #(.TPROG_CYCLES(8)) u_sca_master (
      .clk, .srst, .lnk(lnk), .usr_req(ureq), .usr_cmd(ucmd),
      .usr_wdata(uwd), .usr_ready(urdy), .usr_rdata(urd), .usr_rvalid(urv),
      .usr_rtimeout(uto), .crc_clear(cclr), .crc_valid(cval),
      .crc_index(cidx), .crc_data(cdat), .crc_value(crc));
   sca_link_monitor #(.CMD_ENT_CYCLES(64)) u_sca_link_monitor (
      .clk, .srst, .req(lnk.req), .cmd(lnk.cmd), .wdata(lnk.wdata),
      .rdata(lnk.rdata), .rvalid(lnk.rvalid));
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Reset for 16 cycles, then wait out the start-up check
   task automatic rst(logic init);
      int i;
      @(posedge clk);
      nvm_init <= init;
      srst <= 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
      chk("start-up busy", 16'h0000, {15'h0, busy});
   endtask
   // One transaction through the master's user port
   task automatic op(logic [7:0] c, logic [15:0] d);
      int i;
      for (i = 0; i < 40; i++) begin
         @(negedge clk);
         if (urdy === 1'b1) break;
      end
      @(posedge clk);
      ureq <= 1'b1;
      ucmd <= c;
      uwd <= d;
      @(posedge clk);
      ureq <= 1'b0;
      for (i = 0; i < 40 && c[0]; i++) begin
         @(negedge clk);
         if (urv === 1'b1 || uto === 1'b1) break;
      end
      rd = urd;
      to = uto;
   endtask
   task automatic pulse(logic [4:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 5'h00;
   endtask
   task automatic t_lock();
      rst(1'b1);
      op(8'h83, 16'h0000);
      chk("locked read", 16'h0001, {15'h0, to});
      op(8'h94, 16'hB96B);
      op(8'h83, 16'h0000);
      chk("bad signature", 16'h0001, {15'h0, to});
      op(8'h94, 16'hB96A);
      op(8'h83, 16'h0000);
      chk("diag after unlock", 16'h0000, rd);
      chk("command mode", 16'h0001, {15'h0, cm});
      op(8'h87, 16'h0000);
      chk("reserved register", 16'h0000, rd);
      chk("reserved answered", 16'h0000, {15'h0, to});
   endtask
   task automatic t_crc();
      int a, b;
      logic [7:0] c;
      logic [15:0] w;
      c = 8'hFF;
      @(posedge clk) cclr <= 1'b1;
      @(posedge clk) cclr <= 1'b0;
      for (a = 0; a < 15; a++) begin
         op({3'h0, a[3:0], 1'b1}, 16'h0000);
         w = (a == 14) ? {rd[15:8], 8'h00} : rd;
         for (b = 15; b >= 0; b--) begin
            c = {c[6:0], w[b]} ^ (c[7] ? 8'h07 : 8'h00);
         end
         @(posedge clk);
         cval <= 1'b1;
         cidx <= a[3:0];
         cdat <= rd;
         @(posedge clk);
         cval <= 1'b0;
      end
      caddr <= 4'hE;
      @(negedge clk);
      chk("checksum", 16'h00DB, {8'h00, c});
      chk("stored sum", {8'h00, c}, {8'h00, cfg[7:0]});
      chk("master sum", {8'h00, c}, {8'h00, crc});
   endtask
   task automatic t_nvm();
      op(8'h02, 16'h1234);
      op(8'h03, 16'h0000);
      chk("customer word", 16'h1234, rd);
      op(8'h1E, 16'h5A5A);
      op(8'h1F, 16'h0000);
      chk("reserved word", 16'h0000, rd);
   endtask
   task automatic t_diag();
      int k;
      logic [15:0] e;
      logic [15:0] f [4] = '{16'h1000, 16'h0020, 16'h0100, 16'h0080};
      pulse(5'h10);
      op(8'h83, 16'h0000);
      chk("field loss", 16'h0040, rd);
      chk("gated diag", 16'h0000, {15'h0, dout});
      @(posedge clk) fle <= 1'b1;
      op(8'h83, 16'h0000);
      chk("diag active", 16'h8040, rd);
      op(8'h82, 16'h4000);
      op(8'h83, 16'h0000);
      chk("forced off", 16'h8040, rd & 16'hBFFF);
      chk("diag output", 16'h0000, {15'h0, dout});
      e = 16'h8040;
      for (k = 0; k < 4; k++) begin
         pulse(5'h01 << k);
         e = e | f[k];
         op(8'h83, 16'h0000);
         chk("sticky flag", e, rd & 16'hBFFF);
      end
      @(posedge clk) ang <= 12'hD00;
      op(8'h83, 16'h0000);
      chk("above range", e | 16'h0008, rd & 16'hBFFF);
      @(posedge clk) ang <= 12'h100;
      op(8'h83, 16'h0000);
      chk("below range", e | 16'h0004, rd & 16'hBFFF);
      @(posedge clk) ang <= 12'h800;
   endtask
   task automatic t_bad();
      op(8'h1C, 16'h0000);
      rst(1'b0);
      op(8'h94, 16'hB96A);
      op(8'h83, 16'h0000);
      chk("start-up check", 16'h8010, rd & 16'hBFFF);
      chk("override reset", 16'h0001, {15'h0, dout});
   endtask
   task automatic t_late();
      rst(1'b1);
      repeat (80) @(posedge clk);
      op(8'h94, 16'hB96A);
      op(8'h83, 16'h0000);
      chk("late unlock", 16'h0001, {15'h0, to});
   endtask
   // Time-zero values, then the scenarios
   initial begin
      {srst, nvm_init, fle, ureq, cclr, cval, ev} = 11'h600;
      {ucmd, uwd, cdat, cidx, caddr} = 48'h0;
      ang = 12'h800;
      t_lock();
      t_crc();
      t_nvm();
      t_diag();
      t_bad();
      t_late();
      end_of_test();
   end
endmodule
